// ==== src/lsi_top.sv ====
/*
 Status indicator top: maps device state to one dual-colour power
 indicator and one dual-colour traffic indicator per channel.
 Assumes all status inputs synchronous to sys_clk; per-channel events
 are one-cycle pulses, the rest are levels.
*/
`timescale 1ns/100ps
module lsi_top #(
	parameter int NUM_CH = lsi_pkg::NUM_CH,
	parameter int TICK_CYC = lsi_pkg::TICK_CYC,
	parameter int SLOW_HALF = lsi_pkg::SLOW_HALF_MS,
	parameter int FAST_HALF = lsi_pkg::FAST_HALF_MS,
	parameter int FLASH_TICKS = lsi_pkg::FLASH_MS,
	parameter int RUN_STEP = lsi_pkg::RUN_STEP_MS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic logger_mode,
	input wire logic usb_configured,
	input wire logic fw_cfg_error,
	input wire logic power_problem,
	input wire logic fw_update,
	input wire logic tool_connected,
	input wire logic disk_busy,
	input wire logic hw_error,
	input wire logic battery_fault,
	input wire logic disk_fault,
	input wire logic config_bad,
	input wire logic script_load_fail,
	input wire logic log_armed,
	input wire logic log_active,
	input wire logic log_stopped,
	input wire logic [NUM_CH-1:0] frame_evt,
	input wire logic [NUM_CH-1:0] err_frame_evt,
	input wire logic [NUM_CH-1:0] err_passive,
	input wire logic [NUM_CH-1:0] rx_overrun,
	input wire logic [NUM_CH-1:0] bus_off,
	input wire logic [NUM_CH:0] script_ovr_en,
	input wire logic [2*NUM_CH+1:0] script_ovr_val,
	output logic power_indicator_label_green,
	output logic power_indicator_label_yellow,
	output logic [NUM_CH-1:0] traffic_yellow,
	output logic [NUM_CH-1:0] traffic_red
);
	localparam int NSTEP = 2 * NUM_CH + 2;

	// All checks below run on sys_clk and sleep through reset
	default clocking sys_cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	lsi_tick_if ph();

	lsi_rate_gen #(
		.TICK_CYC(TICK_CYC),
		.SLOW_HALF(SLOW_HALF),
		.FAST_HALF(FAST_HALF),
		.RUN_STEP(RUN_STEP)
	) u_rate (
		.sys_clk(sys_clk),
		.rst(rst),
		.ph(ph)
	);

	logic [NUM_CH-1:0] fl_y;
	logic [NUM_CH-1:0] fl_r;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		lsi_flash #(.FLASH_TICKS(FLASH_TICKS)) u_fy (
			.sys_clk(sys_clk),
			.rst(rst),
			.tick(ph.tick),
			.event_in(frame_evt[c]),
			.lit(fl_y[c])
		);
		lsi_flash #(.FLASH_TICKS(FLASH_TICKS)) u_fr (
			.sys_clk(sys_clk),
			.rst(rst),
			.tick(ph.tick),
			.event_in(err_frame_evt[c]),
			.lit(fl_r[c])
		);
	end

	typedef struct packed {
		logic [NUM_CH-1:0] ovr;
		logic [7:0] run_pos;
		logic pwr_g;
		logic pwr_y;
		logic [NUM_CH-1:0] tr_y;
		logic [NUM_CH-1:0] tr_r;
	} lsi_top_s;
	lsi_top_s r, next_r;

	// Two-colour value of a pattern: {second, first}
	function automatic logic [1:0] pat(input lsi_pkg::lsi_pat_e p,
		input logic slow, input logic fast);
		unique case (p)
			lsi_pkg::LSI_OFF: pat = 2'h0;
			lsi_pkg::LSI_ON1: pat = 2'h1;
			lsi_pkg::LSI_ON2: pat = 2'h2;
			lsi_pkg::LSI_SLOW1: pat = {1'b0, slow};
			lsi_pkg::LSI_SLOW2: pat = {slow, 1'b0};
			lsi_pkg::LSI_FAST1: pat = {1'b0, fast};
			lsi_pkg::LSI_FAST2: pat = {fast, 1'b0};
			lsi_pkg::LSI_SWAVER: pat = {~slow, slow};
			lsi_pkg::LSI_FWAVER: pat = {~fast, fast};
			default: pat = 2'h0;
		endcase
	endfunction

	lsi_pkg::lsi_mode_e mode;
	lsi_pkg::lsi_pat_e pwr_p;
	lsi_pkg::lsi_pat_e all_p;
	logic all_forced;

	// Device-wide mode, highest priority first
	always_comb begin
		if (tool_connected)
			mode = lsi_pkg::LSI_M_TOOL;
		else if (logger_mode && hw_error)
			mode = lsi_pkg::LSI_M_LFW;
		else if (logger_mode && battery_fault)
			mode = lsi_pkg::LSI_M_LBAT;
		else if (logger_mode && disk_fault)
			mode = lsi_pkg::LSI_M_LDISK;
		else if (logger_mode && (config_bad || script_load_fail))
			mode = lsi_pkg::LSI_M_LCFG;
		else if (!logger_mode && !usb_configured)
			mode = lsi_pkg::LSI_M_NOCFG;
		else if (!logger_mode && fw_cfg_error)
			mode = lsi_pkg::LSI_M_FWCFG;
		else if (!logger_mode && power_problem)
			mode = lsi_pkg::LSI_M_PWR;
		else if (disk_busy)
			mode = lsi_pkg::LSI_M_DISK;
		else if (fw_update)
			mode = lsi_pkg::LSI_M_FWUPD;
		else
			mode = lsi_pkg::LSI_M_NORMAL;
	end

	// Power is {yellow, green}; traffic is {red, yellow}
	always_comb begin
		all_forced = 1'b1;
		all_p = lsi_pkg::LSI_OFF;
		pwr_p = lsi_pkg::LSI_ON1;
		unique case (mode)
			lsi_pkg::LSI_M_TOOL: begin
				pwr_p = lsi_pkg::LSI_RUN;
				all_p = lsi_pkg::LSI_RUN;
			end
			lsi_pkg::LSI_M_LFW: begin
				pwr_p = lsi_pkg::LSI_FWAVER;
				all_p = lsi_pkg::LSI_FWAVER;
			end
			lsi_pkg::LSI_M_LBAT: begin
				pwr_p = lsi_pkg::LSI_FWAVER;
				all_p = lsi_pkg::LSI_SWAVER;
			end
			lsi_pkg::LSI_M_LDISK: begin
				pwr_p = lsi_pkg::LSI_ON2;
				all_p = lsi_pkg::LSI_SLOW2;
			end
			lsi_pkg::LSI_M_LCFG: begin
				pwr_p = lsi_pkg::LSI_ON2;
				all_p = lsi_pkg::LSI_FAST2;
			end
			lsi_pkg::LSI_M_NOCFG: begin
				pwr_p = lsi_pkg::LSI_SLOW2;
				all_p = lsi_pkg::LSI_OFF;
			end
			lsi_pkg::LSI_M_FWCFG: begin
				pwr_p = lsi_pkg::LSI_SWAVER;
				all_p = lsi_pkg::LSI_SWAVER;
			end
			lsi_pkg::LSI_M_PWR: begin
				pwr_p = lsi_pkg::LSI_SWAVER;
				all_p = lsi_pkg::LSI_SLOW1;
			end
			lsi_pkg::LSI_M_DISK: begin
				pwr_p = lsi_pkg::LSI_ON1;
				all_p = lsi_pkg::LSI_FAST1;
			end
			lsi_pkg::LSI_M_FWUPD: begin
				all_p = lsi_pkg::LSI_FAST1;
			end
			lsi_pkg::LSI_M_NORMAL: begin
				all_forced = 1'b0;
				if (!logger_mode)
					pwr_p = lsi_pkg::LSI_ON1;
				else if (log_active)
					pwr_p = lsi_pkg::LSI_FAST1;
				else if (log_stopped)
					pwr_p = lsi_pkg::LSI_SLOW1;
				else if (log_armed)
					pwr_p = lsi_pkg::LSI_ON1;
				else
					pwr_p = lsi_pkg::LSI_OFF;
			end
		endcase
	end

	always_comb begin
		logic [1:0] v;
		logic [1:0] p2;
		v = 2'h0;
		p2 = 2'h0;
		next_r = r;
		for (int c = 0; c < NUM_CH; c++) begin
			// Overrun set wins over bus-off clear in the same cycle
			if (rx_overrun[c])
				next_r.ovr[c] = 1'b1;
			else if (bus_off[c])
				next_r.ovr[c] = 1'b0;
		end
		if (mode != lsi_pkg::LSI_M_TOOL)
			next_r.run_pos = 8'h00;
		else if (ph.run_step)
			next_r.run_pos = (r.run_pos == 8'(NSTEP - 1)) ? 8'h00
				: r.run_pos + 8'h01;
		if (pwr_p == lsi_pkg::LSI_RUN)
			p2 = {r.run_pos == 8'h01, r.run_pos == 8'h00};
		else
			p2 = pat(pwr_p, ph.slow_ph, ph.fast_ph);
		next_r.pwr_g = p2[0];
		next_r.pwr_y = p2[1];
		if (script_ovr_en[0]) begin
			next_r.pwr_g = script_ovr_val[0];
			next_r.pwr_y = script_ovr_val[1];
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (all_p == lsi_pkg::LSI_RUN)
				v = {r.run_pos == 8'(2 * c + 3), r.run_pos == 8'(2 * c + 2)};
			else if (all_forced)
				v = pat(all_p, ph.slow_ph, ph.fast_ph);
			else if (r.ovr[c])
				v = 2'h2;
			else if (err_passive[c])
				v = {ph.fast_ph, 1'b0};
			else
				v = {fl_r[c], fl_y[c] & ~fl_r[c]};
			if (script_ovr_en[c+1])
				v = script_ovr_val[2*c+3 -: 2];
			next_r.tr_y[c] = v[0];
			next_r.tr_r[c] = v[1];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign power_indicator_label_green = r.pwr_g;
	assign power_indicator_label_yellow = r.pwr_y;
	assign traffic_yellow = r.tr_y;
	assign traffic_red = r.tr_r;

	sequence ovr_set_s;
		rx_overrun[0] && !bus_off[0];
	endsequence

	sequence ovr_clr_s;
		bus_off[0] && !rx_overrun[0];
	endsequence

	overrun_hold_a: assert property (
		ovr_set_s ##1 (!bus_off[0] && !rx_overrun[0])[*2] |-> r.ovr[0])
		else $error("overrun flag lost before bus-off");

	bus_off_clr_a: assert property (ovr_clr_s |=> !r.ovr[0])
		else $error("overrun flag survived bus-off");

	nocfg_dark_a: assert property (
		(mode == lsi_pkg::LSI_M_NOCFG && script_ovr_en == '0)
		|=> traffic_red == '0 && traffic_yellow == '0)
		else $error("traffic lit before configuration");

	iface_green_a: assert property (
		(mode == lsi_pkg::LSI_M_NORMAL && !logger_mode && !script_ovr_en[0])
		|=> power_indicator_label_green && !power_indicator_label_yellow)
		else $error("power not steady green");

	// Outputs in the first cycle after reset still hold reset values
	run_one_a: assert property (
		(!$past(rst) && $past(mode) == lsi_pkg::LSI_M_TOOL
			&& $past(script_ovr_en) == '0)
		|-> $onehot({power_indicator_label_green,
			power_indicator_label_yellow, traffic_yellow, traffic_red}))
		else $error("running pattern not one colour");

	disk_red_a: assert property (
		(mode == lsi_pkg::LSI_M_LDISK && script_ovr_en == '0)
		|=> traffic_red == {NUM_CH{$past(ph.slow_ph)}}
			&& power_indicator_label_yellow)
		else $error("disk fault pattern wrong");

	fault_prio_a: assert property (
		(mode == lsi_pkg::LSI_M_LFW && script_ovr_en == '0)
		|=> traffic_yellow == {NUM_CH{$past(ph.fast_ph)}}
			&& traffic_red == ~traffic_yellow)
		else $error("fault did not override channel status");

	waver_two_a: assert property (
		(mode == lsi_pkg::LSI_M_FWCFG && !script_ovr_en[0])
		|=> power_indicator_label_green == $past(ph.slow_ph)
			&& power_indicator_label_yellow != $past(ph.slow_ph))
		else $error("power waver not alternating");

	script_ovr_a: assert property (
		script_ovr_en[0] |=> power_indicator_label_green
			== $past(script_ovr_val[0]))
		else $error("script override ignored");

	flash_red_a: assert property (
		(mode == lsi_pkg::LSI_M_NORMAL && fl_r[1] && !r.ovr[1]
			&& !err_passive[1] && !script_ovr_en[2])
		|=> traffic_red[1] && !traffic_yellow[1])
		else $error("error frame flash not red");

	logger_on_a: assert property (
		(mode == lsi_pkg::LSI_M_NORMAL && logger_mode && log_armed
			&& !log_active && !log_stopped && !script_ovr_en[0])
		|=> power_indicator_label_green && !power_indicator_label_yellow)
		else $error("armed logger not steady green");
endmodule

// ==== src/lsi_pkg.sv ====
/*
 Shared constants and types for the status indicator block.
 Assumes a 125 MHz system clock; blink rates are design choices.
*/
package lsi_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int FLASH_MS = 20;
	localparam int SLOW_HALF_MS = 500;
	localparam int FAST_HALF_MS = 125;
	localparam int RUN_STEP_MS = 100;
	localparam int TICK_US = 1000;
	// Cycles per 1 ms tick, rounded down as a period
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam int NUM_CH = 5;

	// Per-indicator colour drive: bit 0 first colour, bit 1 second colour
	typedef enum {
		LSI_OFF, LSI_ON1, LSI_ON2, LSI_SLOW1, LSI_SLOW2, LSI_FAST1,
		LSI_FAST2, LSI_SWAVER, LSI_FWAVER, LSI_FLASH1, LSI_FLASH2, LSI_RUN
	} lsi_pat_e;

	typedef enum {
		LSI_M_NORMAL, LSI_M_NOCFG, LSI_M_FWCFG, LSI_M_PWR, LSI_M_FWUPD,
		LSI_M_TOOL, LSI_M_DISK, LSI_M_LFW, LSI_M_LBAT, LSI_M_LDISK,
		LSI_M_LCFG
	} lsi_mode_e;
endpackage

// ==== src/lsi_tick_if.sv ====
/*
 Timing phases carried from the rate generator to the pattern logic.
 Assumes one clock domain; all fields are registered; tick and run_step are one-cycle pulses, the phases levels.
*/
`timescale 1ns/100ps
interface lsi_tick_if;
	logic tick;
	logic slow_ph;
	logic fast_ph;
	logic run_step;
	modport gen (output tick, slow_ph, fast_ph, run_step);
	modport use_ph (input tick, slow_ph, fast_ph, run_step);
endinterface

// ==== src/lsi_rate_gen.sv ====
/*
 Rate generator: millisecond tick, slow and fast square phases,
 running-pattern step pulse. Assumes sys_clk at the package rate.
*/
`timescale 1ns/100ps
module lsi_rate_gen #(
	parameter int TICK_CYC = lsi_pkg::TICK_CYC,
	parameter int SLOW_HALF = lsi_pkg::SLOW_HALF_MS,
	parameter int FAST_HALF = lsi_pkg::FAST_HALF_MS,
	parameter int RUN_STEP = lsi_pkg::RUN_STEP_MS
) (
	input wire logic sys_clk,
	input wire logic rst,
	lsi_tick_if.gen ph
);
	typedef struct packed {
		logic [31:0] pre;
		logic [15:0] slow_cnt;
		logic [15:0] fast_cnt;
		logic [15:0] run_cnt;
		logic tick;
		logic slow_ph;
		logic fast_ph;
		logic run_step;
	} lsi_rg_s;
	lsi_rg_s r, next_r;

	function automatic logic [15:0] wrap(input logic [15:0] c, input int n);
		wrap = (c == 16'(n - 1)) ? 16'h0000 : c + 16'h0001;
	endfunction

	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		next_r.run_step = 1'b0;
		if (r.pre == 32'(TICK_CYC - 1)) begin
			next_r.pre = 32'h0;
			next_r.tick = 1'b1;
		end else begin
			next_r.pre = r.pre + 32'h1;
		end
		if (r.tick) begin
			// Equal on and off halves; fast is the shorter half period
			next_r.slow_cnt = wrap(r.slow_cnt, SLOW_HALF);
			if (r.slow_cnt == 16'(SLOW_HALF - 1))
				next_r.slow_ph = ~r.slow_ph;
			next_r.fast_cnt = wrap(r.fast_cnt, FAST_HALF);
			if (r.fast_cnt == 16'(FAST_HALF - 1))
				next_r.fast_ph = ~r.fast_ph;
			next_r.run_cnt = wrap(r.run_cnt, RUN_STEP);
			if (r.run_cnt == 16'(RUN_STEP - 1))
				next_r.run_step = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign ph.tick = r.tick;
	assign ph.slow_ph = r.slow_ph;
	assign ph.fast_ph = r.fast_ph;
	assign ph.run_step = r.run_step;

	fast_toggle_a: assert property (@(posedge sys_clk)
		disable iff (rst) $changed(r.fast_ph) |-> $past(r.tick))
		else $error("fast phase moved without a tick");
endmodule

// ==== src/lsi_flash.sv ====
/*
 Flash stretcher for one colour: an event lights it for a fixed number
 of ticks; repeated events keep it lit. Assumes tick from rate gen.
*/
`timescale 1ns/100ps
module lsi_flash #(
	parameter int FLASH_TICKS = lsi_pkg::FLASH_MS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic event_in,
	output logic lit
);
	typedef struct packed {
		logic [15:0] cnt;
	} lsi_fl_s;
	lsi_fl_s r, next_r;

	always_comb begin
		next_r = r;
		// New event wins over the countdown so none is lost
		if (event_in)
			next_r.cnt = 16'(FLASH_TICKS);
		else if (tick && r.cnt != 16'h0000)
			next_r.cnt = r.cnt - 16'h0001;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign lit = (r.cnt != 16'h0000);

	flash_start_a: assert property (@(posedge sys_clk)
		disable iff (rst) event_in |=> lit)
		else $error("flash not lit after event");
endmodule

// ==== verification/lsi_led_view.sv ====
/*
 Operator's view of the indicators: per colour lamp, the current run
 length and the last complete lit and dark runs, in sys_clk cycles.
 Assumes lamp 0 power green, 1 power yellow, then yellow and red of
 each channel in turn.
*/
`timescale 1ns/100ps
module lsi_led_view #(
	parameter int NL = 12
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [NL-1:0] lamp,
	output int run [NL],
	output int on_len [NL],
	output int off_len [NL]
);
	logic [NL-1:0] prev;

	// An eye sees only run lengths, so blink timing is judged that way
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prev <= '0;
			for (int i = 0; i < NL; i++) begin
				run[i] <= 0;
				on_len[i] <= 0;
				off_len[i] <= 0;
			end
		end else begin
			prev <= lamp;
			for (int i = 0; i < NL; i++) begin
				if (lamp[i] === prev[i]) begin
					run[i] <= run[i] + 1;
				end else begin
					run[i] <= 1;
					if (prev[i])
						on_len[i] <= run[i];
					else
						off_len[i] <= run[i];
				end
			end
		end
	end
endmodule

// ==== verification/led_status_indicator_test.sv ====
/*
 Self-checking bench for the status indicator top.
 Assumes short rate parameters: 4-cycle tick, so slow half 16 cycles,
 fast half 8, running step 8; inputs change at the falling edge.
*/
`timescale 1ns/100ps
module led_status_indicator_test;
	localparam int N = 5;
	localparam int NL = 2 * N + 2;
	localparam int S = 16;
	localparam int F = 8;
	localparam int X = 99;
	localparam logic [14:0] M_LOG = 15'h0001;
	localparam logic [14:0] M_USB = 15'h0002;
	logic sys_clk;
	logic rst;
	logic [14:0] lv;
	logic [N-1:0] frame_evt;
	logic [N-1:0] err_frame_evt;
	logic [N-1:0] err_passive;
	logic [N-1:0] rx_overrun;
	logic [N-1:0] bus_off;
	logic [N:0] ovr_en;
	logic [2*N+1:0] ovr_val;
	logic pg;
	logic py;
	logic [N-1:0] ty;
	logic [N-1:0] tr;
	logic [NL-1:0] lamp;
	int run [NL];
	int on_len [NL];
	int off_len [NL];
	int error_cnt;
	int checked;

	always_comb begin
		lamp[0] = pg;
		lamp[1] = py;
		for (int c = 0; c < N; c++) begin
			lamp[2+2*c] = ty[c];
			lamp[3+2*c] = tr[c];
		end
	end

	lsi_top #(.NUM_CH(N), .TICK_CYC(4), .SLOW_HALF(4), .FAST_HALF(2),
		.FLASH_TICKS(2), .RUN_STEP(2)) lsi_top_i (
		.sys_clk(sys_clk), .rst(rst), .logger_mode(lv[0]),
		.usb_configured(lv[1]), .fw_cfg_error(lv[2]),
		.power_problem(lv[3]), .fw_update(lv[4]), .tool_connected(lv[5]),
		.disk_busy(lv[6]), .hw_error(lv[7]), .battery_fault(lv[8]),
		.disk_fault(lv[9]), .config_bad(lv[10]),
		.script_load_fail(lv[11]), .log_armed(lv[12]),
		.log_active(lv[13]), .log_stopped(lv[14]), .frame_evt(frame_evt),
		.err_frame_evt(err_frame_evt), .err_passive(err_passive),
		.rx_overrun(rx_overrun), .bus_off(bus_off),
		.script_ovr_en(ovr_en), .script_ovr_val(ovr_val),
		.power_indicator_label_green(pg), .power_indicator_label_yellow(py),
		.traffic_yellow(ty), .traffic_red(tr));

	lsi_led_view #(.NL(NL)) lsi_led_view_i (.sys_clk(sys_clk), .rst(rst),
		.lamp(lamp), .run(run), .on_len(on_len), .off_len(off_len));

	task automatic fail(input string msg);
		error_cnt++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask

	task automatic expect_bit(input logic got, input logic exp,
		input string msg);
		checked++;
		if (got !== exp)
			fail(msg);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// Kinds: 0 dark, 1 steady, X free, otherwise a half period
	task automatic chk_lamp(input int i, input int k);
		checked++;
		if (k == 0 || k == 1) begin
			if (lamp[i] !== k[0] || run[i] < 40)
				fail($sformatf("lamp %0d not steady %0d", i, k));
		end else if (k != X) begin
			if (on_len[i] != k || off_len[i] != k)
				fail($sformatf("lamp %0d runs %0d/%0d", i, on_len[i],
					off_len[i]));
		end
	endtask

	// wav bit 0: power colours alternate, bit 1: traffic colours alternate
	task automatic mode_chk(input logic [14:0] v, input int kg, input int ky,
		input int kty, input int ktr, input logic [1:0] wav);
		lv = v;
		wait_cyc(80);
		chk_lamp(0, kg);
		chk_lamp(1, ky);
		if (wav[0])
			expect_bit(pg ^ py, 1'b1, "power colours not alternating");
		for (int c = 0; c < N; c++) begin
			chk_lamp(2 + 2 * c, kty);
			chk_lamp(3 + 2 * c, ktr);
			if (wav[1])
				expect_bit(ty[c] ^ tr[c], 1'b1, "traffic not alternating");
		end
	endtask

	task automatic t_interface;
		mode_chk(M_USB, 1, 0, 0, 0, 2'b00);
		mode_chk(M_USB | 15'h0004, S, S, S, S, 2'b11);
		mode_chk(M_USB | 15'h0008, S, S, S, 0, 2'b01);
		mode_chk(M_USB | 15'h0010, X, X, F, 0, 2'b00);
		mode_chk(M_USB | 15'h0040, 1, 0, F, 0, 2'b00);
	endtask

	task automatic t_channels;
		lv = M_USB;
		wait_cyc(10);
		for (int k = 0; k < 8; k++) begin
			frame_evt[0] = 1'b1;
			wait_cyc(1);
			frame_evt[0] = 1'b0;
			wait_cyc(2);
			expect_bit(ty[0], 1'b1, "yellow flash not lit");
		end
		wait_cyc(20);
		expect_bit(ty[0], 1'b0, "yellow flash stuck");
		err_frame_evt[1] = 1'b1;
		wait_cyc(1);
		err_frame_evt[1] = 1'b0;
		wait_cyc(1);
		expect_bit(tr[1], 1'b1, "red flash not lit");
		expect_bit(ty[1], 1'b0, "yellow on error frame");
		err_passive[2] = 1'b1;
		// Channels 0 and 3 overrun; channel 0 also feeds the hold checks
		rx_overrun = 5'h09;
		wait_cyc(1);
		rx_overrun = '0;
		wait_cyc(80);
		chk_lamp(7, F);
		chk_lamp(9, 1);
		chk_lamp(3, 1);
		chk_lamp(2, 0);
		bus_off = 5'h09;
		wait_cyc(3);
		expect_bit(tr[3], 1'b0, "overrun outlived bus-off");
		expect_bit(tr[0], 1'b0, "overrun outlived bus-off");
		bus_off = '0;
	endtask

	task automatic t_running;
		int cur;
		int nxt;
		int steps;
		lv = M_USB | 15'h0020;
		wait_cyc(20);
		cur = -1;
		steps = 0;
		for (int t = 0; t < 200; t++) begin
			checked++;
			if (lamp === '0 || (lamp & (lamp - 1'b1)) !== '0) begin
				fail("running shows other than one lamp");
			end else begin
				for (int i = 0; i < NL; i++)
					if (lamp[i] === 1'b1)
						nxt = i;
				if (cur >= 0 && nxt != cur) begin
					steps++;
					if (nxt != (cur + 1) % NL)
						fail("running order broken");
				end
				cur = nxt;
			end
			wait_cyc(1);
		end
		checked++;
		if (steps < 20)
			fail("running pattern too slow");
	endtask

	// Channel 2 stays error passive through the faults to test masking
	task automatic t_logger;
		mode_chk(M_LOG | 15'h0080, F, F, F, F, 2'b11);
		mode_chk(M_LOG | 15'h0100, F, F, S, S, 2'b11);
		mode_chk(M_LOG | 15'h0200, 0, 1, 0, S, 2'b00);
		mode_chk(M_LOG | 15'h0400, 0, 1, 0, F, 2'b00);
		mode_chk(M_LOG | 15'h0800, 0, 1, 0, F, 2'b00);
		err_passive[2] = 1'b0;
		mode_chk(M_LOG, 0, 0, 0, 0, 2'b00);
		mode_chk(M_LOG | 15'h1000, 1, 0, 0, 0, 2'b00);
		mode_chk(M_LOG | 15'h3000, F, 0, 0, 0, 2'b00);
		mode_chk(M_LOG | 15'h4000, S, 0, 0, 0, 2'b00);
	endtask

	task automatic t_script;
		lv = M_USB;
		ovr_val[1:0] = 2'b10;
		ovr_val[11:10] = 2'b11;
		ovr_en = 6'h21;
		wait_cyc(80);
		chk_lamp(0, 0);
		chk_lamp(1, 1);
		chk_lamp(10, 1);
		chk_lamp(11, 1);
		ovr_en = '0;
		wait_cyc(80);
		chk_lamp(0, 1);
		chk_lamp(11, 0);
	endtask

	task automatic end_of_test;
		$display("mismatches %0d, comparisons %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial begin
		rst = 1'b1;
		lv = '0;
		frame_evt = '0;
		err_frame_evt = '0;
		err_passive = '0;
		rx_overrun = '0;
		bus_off = '0;
		ovr_en = '0;
		ovr_val = '0;
		error_cnt = 0;
		checked = 0;
		wait_cyc(10);
		expect_bit(|lamp, 1'b0, "lamp lit in reset");
		rst = 1'b0;
		mode_chk('0, 0, S, 0, 0, 2'b00);
		t_interface();
		t_channels();
		t_running();
		t_logger();
		t_script();
		end_of_test();
	end

	// Whole run is about 1730 cycles; this allows ample margin
	initial begin
		#200000;
		fail("watchdog expired");
		end_of_test();
	end
endmodule
